// >>> include/gtg_reg_map.vh
// register map and field layout of the two-timer group
// assumes byte addresses on an APB bus with 32-bit data
`ifndef GTG_REG_MAP_VH
`define GTG_REG_MAP_VH

// per-timer register offsets, relative to the timer base
`define GTG_OFF_CFG      8'h00
`define GTG_OFF_SNAP_LO  8'h04
`define GTG_OFF_SNAP_HI  8'h08
`define GTG_OFF_SNAP_TRG 8'h0c
`define GTG_OFF_ALM_LO   8'h10
`define GTG_OFF_ALM_HI   8'h14
`define GTG_OFF_LD_LO    8'h18
`define GTG_OFF_LD_HI    8'h1c
`define GTG_OFF_LD_TRG   8'h20

// timer bases
`define GTG_T0_BASE      8'h00
`define GTG_T1_BASE      8'h24

// group interrupt registers
`define GTG_INT_ENA      8'h98
`define GTG_INT_RAW      8'h9c
`define GTG_INT_ST       8'ha0
`define GTG_INT_CLR      8'ha4

// timer_config field positions
`define GTG_CFG_EN       31
`define GTG_CFG_UP       30
`define GTG_CFG_AUTO     29
`define GTG_CFG_DIV_HI   28
`define GTG_CFG_DIV_LO   13
`define GTG_CFG_EDGE_EN  12
`define GTG_CFG_LVL_EN   11
`define GTG_CFG_ALM_EN   10
`define GTG_CFG_XTAL     9

// reset values
`define GTG_RST_UP       1'b1
`define GTG_RST_DIV      16'h0001
`define GTG_RST_WORD     32'h0000_0000
`define GTG_RST_DWORD    64'h0000_0000_0000_0000

// interrupt bit positions and widths, and the prescaler divisor used for a zero divisor field
`define GTG_IRQ_WDT      2
`define GTG_IRQ_W        3
`define GTG_DIV_ZERO     17'h10000

`endif

// >>> rtl/gtg_timer_group.v
// two general purpose 64-bit timers with prescalers, alarms, reload and
// the group interrupt registers, behind an APB slave
// assumes the watchdog timeout pulse comes from logic on sys_clk and the
// crystal clock arrives on a pin and is slower than half of sys_clk
//
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "gtg_reg_map.vh"

module gtg_timer_chan (
    input  wire        sys_clk,            // system clock
    input  wire        resetn,             // async reset, active low
    input  wire        xtalTick,           // one pulse per rising crystal clock edge
    input  wire        cfgWr,              // timer_config write
    input  wire        almLoWr,            // alarm_value_low write
    input  wire        almHiWr,            // alarm_value_high write
    input  wire        ldLoWr,             // reload_value_low write
    input  wire        ldHiWr,             // reload_value_high write
    input  wire        snapWr,             // snapshot_trigger write
    input  wire        reloadWr,           // reload_trigger write
    input  wire [31:0] wdata,              // bus write data
    output wire [31:0] cfgRd,              // timer_config read view
    output wire [63:0] snapVal,            // snapshot readback
    output wire [63:0] almVal,             // alarm value
    output wire [63:0] ldVal,              // reload value
    output wire        levelIrqEnable,     // level line enable
    output wire        edgeIrqEnable,      // edge line enable
    output wire        alarmHit            // alarm event, one cycle
);
    reg        counterEnableQ;
    reg        countUpDirectionQ;
    reg        autoReloadEnableQ;
    reg [15:0] prescaleDivisorQ;
    reg        edgeIrqEnableQ;
    reg        levelIrqEnableQ;
    reg        alarmEnableQ;
    reg        sourceClockSelectQ;
    reg [15:0] preCntQ;
    reg [63:0] cntQ;
    reg [63:0] almQ;
    reg [63:0] ldQ;
    reg [63:0] snapQ;

    wire        srcTick;
    wire [16:0] effDiv;
    wire        lastPre;
    wire        tick;

    // source select and prescaler
    assign srcTick = sourceClockSelectQ ? xtalTick : 1'b1;
    assign effDiv  = (prescaleDivisorQ == 16'h0000) ? `GTG_DIV_ZERO
                                                    : {1'b0, prescaleDivisorQ};
    assign lastPre = (({1'b0, preCntQ} + 17'h00001) == effDiv);
    assign tick    = counterEnableQ & srcTick & lastPre;

    // alarm compare, including the late-enable case
    assign alarmHit = alarmEnableQ &
                      (countUpDirectionQ ? (cntQ >= almQ)
                                         : (cntQ <= almQ));

    assign cfgRd = {counterEnableQ, countUpDirectionQ, autoReloadEnableQ, prescaleDivisorQ,
                    edgeIrqEnableQ, levelIrqEnableQ, alarmEnableQ, sourceClockSelectQ, 9'h000};
    assign snapVal        = snapQ;
    assign almVal         = almQ;
    assign ldVal          = ldQ;
    assign levelIrqEnable = levelIrqEnableQ;
    assign edgeIrqEnable  = edgeIrqEnableQ;

    // configuration; a software write wins over the hardware disarm
    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            counterEnableQ     <= 1'b0;
            countUpDirectionQ  <= `GTG_RST_UP;
            autoReloadEnableQ  <= 1'b0;
            prescaleDivisorQ   <= `GTG_RST_DIV;
            edgeIrqEnableQ     <= 1'b0;
            levelIrqEnableQ    <= 1'b0;
            alarmEnableQ       <= 1'b0;
            sourceClockSelectQ <= 1'b0;
        end
        else if (cfgWr)
        begin
            counterEnableQ     <= wdata[`GTG_CFG_EN];
            countUpDirectionQ  <= wdata[`GTG_CFG_UP];
            autoReloadEnableQ  <= wdata[`GTG_CFG_AUTO];
            prescaleDivisorQ   <= wdata[`GTG_CFG_DIV_HI:`GTG_CFG_DIV_LO];
            edgeIrqEnableQ     <= wdata[`GTG_CFG_EDGE_EN];
            levelIrqEnableQ    <= wdata[`GTG_CFG_LVL_EN];
            alarmEnableQ       <= wdata[`GTG_CFG_ALM_EN];
            sourceClockSelectQ <= wdata[`GTG_CFG_XTAL];
        end
        else if (alarmHit)
        begin
            alarmEnableQ <= 1'b0;
        end
    end

    // prescaler count, restarted while the timer is off
    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            preCntQ <= 16'h0000;
        else if (!counterEnableQ)
            preCntQ <= 16'h0000;
        else if (srcTick)
            preCntQ <= lastPre ? 16'h0000 : (preCntQ + 16'h0001);
    end

    // time-base counter: software reload, then auto reload, then step
    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            cntQ <= `GTG_RST_DWORD;
        else if (reloadWr)
            cntQ <= ldQ;
        else if (alarmHit && autoReloadEnableQ)
            cntQ <= ldQ;
        else if (tick)
            cntQ <= countUpDirectionQ ? (cntQ + 64'h1) : (cntQ - 64'h1);
    end

    // alarm and reload values; writing them never touches the counter
    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            almQ <= `GTG_RST_DWORD;
            ldQ  <= `GTG_RST_DWORD;
        end
        else
        begin
            if (almLoWr)
                almQ[31:0] <= wdata;
            if (almHiWr)
                almQ[63:32] <= wdata;
            if (ldLoWr)
                ldQ[31:0] <= wdata;
            if (ldHiWr)
                ldQ[63:32] <= wdata;
        end
    end

    // snapshot copy, held until the next trigger
    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            snapQ <= `GTG_RST_DWORD;
        else if (snapWr)
            snapQ <= cntQ;
    end
endmodule // gtg_timer_chan

module gtg_timer_group (
    input  wire        sys_clk,            // system clock, 100 MHz
    input  wire        resetn,             // async reset, active low
    input  wire [7:0]  paddr,              // APB byte address
    input  wire        psel,               // APB select
    input  wire        penable,            // APB access phase
    input  wire        pwrite,             // APB direction, high for write
    input  wire [31:0] pwdata,             // APB write data
    output reg  [31:0] prdata,             // APB read data
    output reg         pready,             // APB ready
    output reg         pslverr,            // APB error on unmapped address
    input  wire        crystalClock,       // crystal clock pin
    input  wire        watchdogTimeout,    // watchdog stage timeout pulse
    output reg  [1:0]  timerLevelIrq,      // per-timer level interrupt
    output reg  [1:0]  timerEdgeIrq,       // per-timer edge interrupt
    output reg         watchdogLevelIrq,   // watchdog level interrupt
    output reg         watchdogEdgeIrq     // watchdog edge interrupt
);
    reg                   xtalS1Q;
    reg                   xtalS2Q;
    reg                   xtalS3Q;
    reg [`GTG_IRQ_W-1:0]  irqRawQ;
    reg [`GTG_IRQ_W-1:0]  irqMaskEnableQ;
    reg [31:0]            rdMux;
    reg                   intHit;

    wire                  xtalTick;
    wire                  setupPh;
    wire                  wrEn;
    wire [63:0]           chanRd;
    wire [1:0]            chanHit;
    wire [1:0]            alarmHit;
    wire [1:0]            lvlEn;
    wire [1:0]            edgeEn;
    wire [`GTG_IRQ_W-1:0] irqSet;
    wire [`GTG_IRQ_W-1:0] irqClr;
    wire [`GTG_IRQ_W-1:0] irqRawD;
    wire [`GTG_IRQ_W-1:0] irqMasked;

    // crystal pin synchroniser; the edge detector compares the second and third stages
    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            xtalS1Q <= 1'b0;
            xtalS2Q <= 1'b0;
            xtalS3Q <= 1'b0;
        end
        else
        begin
            xtalS1Q <= crystalClock;
            xtalS2Q <= xtalS1Q;
            xtalS3Q <= xtalS2Q;
        end
    end
    assign xtalTick = xtalS2Q & ~xtalS3Q;

    // bus phases; writes act at the access edge with pready high
    assign setupPh = psel & ~penable;
    assign wrEn    = psel & penable & pready & pwrite;

    // one channel per timer with its own address window
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1)
        begin : gTmr
            localparam [7:0] BASE = (gi == 0) ? `GTG_T0_BASE : `GTG_T1_BASE;
            wire [7:0]  off;
            wire [31:0] cfgRd;
            wire [63:0] snapVal;
            wire [63:0] almVal;
            wire [63:0] ldVal;
            reg  [31:0] rd;
            reg         hit;

            assign off = paddr - BASE;

            gtg_timer_chan uChan (
                .sys_clk        (sys_clk),
                .resetn         (resetn),
                .xtalTick       (xtalTick),
                .cfgWr          (wrEn & (off == `GTG_OFF_CFG)),
                .almLoWr        (wrEn & (off == `GTG_OFF_ALM_LO)),
                .almHiWr        (wrEn & (off == `GTG_OFF_ALM_HI)),
                .ldLoWr         (wrEn & (off == `GTG_OFF_LD_LO)),
                .ldHiWr         (wrEn & (off == `GTG_OFF_LD_HI)),
                .snapWr         (wrEn & (off == `GTG_OFF_SNAP_TRG)),
                .reloadWr       (wrEn & (off == `GTG_OFF_LD_TRG)),
                .wdata          (pwdata),
                .cfgRd          (cfgRd),
                .snapVal        (snapVal),
                .almVal         (almVal),
                .ldVal          (ldVal),
                .levelIrqEnable (lvlEn[gi]),
                .edgeIrqEnable  (edgeEn[gi]),
                .alarmHit       (alarmHit[gi])
            );

            // read view of this timer's window; trigger words read zero
            always @*
            begin
                rd  = `GTG_RST_WORD;
                hit = 1'b1;
                if (off == `GTG_OFF_CFG)
                    rd = cfgRd;
                else if (off == `GTG_OFF_SNAP_LO)
                    rd = snapVal[31:0];
                else if (off == `GTG_OFF_SNAP_HI)
                    rd = snapVal[63:32];
                else if (off == `GTG_OFF_ALM_LO)
                    rd = almVal[31:0];
                else if (off == `GTG_OFF_ALM_HI)
                    rd = almVal[63:32];
                else if (off == `GTG_OFF_LD_LO)
                    rd = ldVal[31:0];
                else if (off == `GTG_OFF_LD_HI)
                    rd = ldVal[63:32];
                else if (off == `GTG_OFF_SNAP_TRG || off == `GTG_OFF_LD_TRG)
                    rd = `GTG_RST_WORD;
                else
                    hit = 1'b0;
            end

            assign chanRd[gi*32 +: 32] = rd;
            assign chanHit[gi]         = hit;
        end
    endgenerate

    // raw interrupt bits: a new event wins over a clear in the same cycle
    assign irqSet    = {watchdogTimeout, alarmHit};
    assign irqClr    = (wrEn && paddr == `GTG_INT_CLR) ? pwdata[`GTG_IRQ_W-1:0] : 3'h0;
    assign irqRawD   = (irqRawQ & ~irqClr) | irqSet;
    assign irqMasked = irqRawQ & irqMaskEnableQ;

    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            irqRawQ        <= 3'h0;
            irqMaskEnableQ <= 3'h0;
        end
        else
        begin
            irqRawQ <= irqRawD;
            if (wrEn && paddr == `GTG_INT_ENA)
                irqMaskEnableQ <= pwdata[`GTG_IRQ_W-1:0];
        end
    end

    // interrupt lines, level held from the raw bit, edge one cycle wide
    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            timerLevelIrq    <= 2'h0;
            timerEdgeIrq     <= 2'h0;
            watchdogLevelIrq <= 1'b0;
            watchdogEdgeIrq  <= 1'b0;
        end
        else
        begin
            timerLevelIrq    <= irqRawD[1:0] & lvlEn;
            timerEdgeIrq     <= alarmHit & edgeEn;
            watchdogLevelIrq <= irqRawD[`GTG_IRQ_WDT];
            watchdogEdgeIrq  <= watchdogTimeout;
        end
    end

    // group register read view
    always @*
    begin
        rdMux  = chanRd[31:0] | chanRd[63:32];
        intHit = 1'b1;
        if (paddr == `GTG_INT_ENA)
            rdMux = {29'h0000_0000, irqMaskEnableQ};
        else if (paddr == `GTG_INT_RAW)
            rdMux = {29'h0000_0000, irqRawQ};
        else if (paddr == `GTG_INT_ST)
            rdMux = {29'h0000_0000, irqMasked};
        else if (paddr == `GTG_INT_CLR)
            rdMux = `GTG_RST_WORD;
        else
            intHit = 1'b0;
    end

    // APB answer: captured in the setup cycle, one access cycle, no waits
    always @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            prdata  <= `GTG_RST_WORD;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= setupPh;
            pslverr <= setupPh & ~(intHit | (|chanHit));
            if (setupPh && !pwrite)
                prdata <= rdMux;
        end
    end
endmodule // gtg_timer_group

// >>> tb/gtg_timer_group_chk.sv
// port checker for the two-timer group
// assumes it is bound to gtg_timer_group and sees its ports only
`timescale 1ns/1ps
module gtg_timer_group_chk (
    input wire logic        sys_clk,          // clock
    input wire logic        resetn,           // reset, active low
    input wire logic [7:0]  paddr,            // bus address
    input wire logic        psel,             // bus select
    input wire logic        penable,          // access phase
    input wire logic        pwrite,           // write
    input wire logic [31:0] pwdata,           // write data
    input wire logic [31:0] prdata,           // read data
    input wire logic        pready,           // ready
    input wire logic        pslverr,          // error
    input wire logic        watchdogTimeout,  // timeout pulse
    input wire logic [1:0]  timerLevelIrq,    // timer level lines
    input wire logic [1:0]  timerEdgeIrq,     // timer edge lines
    input wire logic        watchdogLevelIrq, // watchdog level line
    input wire logic        watchdogEdgeIrq   // watchdog edge line
);
    // decoded bus events
    wire acc    = psel && penable && pready;
    wire clrW   = acc && pwrite && paddr == 8'ha4;
    wire rel0   = (clrW && pwdata[0]) || (acc && pwrite && paddr == 8'h00);
    wire rel1   = (clrW && pwdata[1]) || (acc && pwrite && paddr == 8'h24);
    wire relW   = clrW && pwdata[2];
    wire mapped = paddr[1:0] == 2'b00 && (paddr <= 8'h44 || (paddr >= 8'h98 && paddr <= 8'ha4));

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready in the access cycle");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_err_mapped: assert property (acc && mapped |-> !pslverr)
        else $error("error on a mapped address");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_clear_reads_zero: assert property (acc && !pwrite && paddr == 8'ha4 |-> prdata == 32'h0)
        else $error("clear word read not zero");
    a_edge_single: assert property (timerEdgeIrq != 2'b00 |=> (timerEdgeIrq & $past(timerEdgeIrq)) == 2'b00)
        else $error("edge interrupt longer than one cycle");
    a_level0_holds: assert property ($fell(timerLevelIrq[0]) |-> $past(rel0) || $past(rel0, 2) || $past(rel0, 3))
        else $error("timer 0 level line dropped without clear");
    a_level1_holds: assert property ($fell(timerLevelIrq[1]) |-> $past(rel1) || $past(rel1, 2) || $past(rel1, 3))
        else $error("timer 1 level line dropped without clear");
    a_wdt_raise: assert property (watchdogTimeout |-> ##[1:2] watchdogLevelIrq)
        else $error("watchdog level line not raised");
    a_wdt_holds: assert property ($fell(watchdogLevelIrq) |-> $past(relW) || $past(relW, 2) || $past(relW, 3))
        else $error("watchdog level line dropped without clear");
    a_wdt_edge: assert property (watchdogTimeout |-> ##[0:2] watchdogEdgeIrq)
        else $error("watchdog edge pulse missing");
endmodule // gtg_timer_group_chk

bind gtg_timer_group gtg_timer_group_chk u_chk (.sys_clk, .resetn, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .watchdogTimeout, .timerLevelIrq, .timerEdgeIrq, .watchdogLevelIrq,
    .watchdogEdgeIrq);

// >>> tb/test_gtg_timer_group.sv
// self-checking bench for the two-timer group
// assumes the design and its checker are compiled before it
`timescale 1ns/1ps
`include "gtg_reg_map.vh"
module test_gtg_timer_group;
    logic        sys_clk, resetn, psel, penable, pwrite, pready, pslverr, err;
    logic        crystalClock, watchdogTimeout, watchdogLevelIrq, watchdogEdgeIrq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, alm;
    logic [63:0] sv, v;
    logic [1:0]  timerLevelIrq, timerEdgeIrq;
    integer      errors, cmp_count, seed, x0, t, u, k, d;
    integer      edgeSeen [0:1];

    gtg_timer_group DUT (.sys_clk, .resetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
        .pslverr, .crystalClock, .watchdogTimeout, .timerLevelIrq, .timerEdgeIrq, .watchdogLevelIrq,
        .watchdogEdgeIrq);

    // bus clock and a free crystal clock of unrelated phase
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial
    begin
        crystalClock = 1'b0;
        forever #37 crystalClock = ~crystalClock;
    end

    // count edge pulses of each timer
    always @(posedge sys_clk)
    begin
        if (timerEdgeIrq[0] === 1'b1)
            edgeSeen[0] <= edgeSeen[0] + 1;
        if (timerEdgeIrq[1] === 1'b1)
            edgeSeen[1] <= edgeSeen[1] + 1;
    end

    function automatic [7:0] rg(input integer tm, input [7:0] off);
        rg = (tm != 0 ? `GTG_T1_BASE : `GTG_T0_BASE) + off;
    endfunction
    function automatic [31:0] cfgw(input en, ud, au, input [15:0] dv, input eg, lv, al, xt);
        cfgw = {en, ud, au, dv, eg, lv, al, xt, 9'h000};
    endfunction

    // one bus transfer, held until ready is sampled high
    task automatic apb(input [7:0] a, input w, input [31:0] wd);
        integer n;
        begin
            @(posedge sys_clk);
            psel    <= 1'b1;
            penable <= 1'b0;
            paddr   <= a;
            pwrite  <= w;
            pwdata  <= wd;
            @(posedge sys_clk);
            penable <= 1'b1;
            n = 0;
            do
            begin
                @(posedge sys_clk);
                n++;
            end
            while (pready !== 1'b1 && n < 16);
            rd = prdata;
            err = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
            chk("pready", 1, pready);
        end
    endtask
    task automatic chk(input string nm, input [63:0] e, input [63:0] g);
        begin
            cmp_count++;
            if (g !== e)
            begin
                errors++;
                $display("[ERR] %s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task automatic near(input string nm, input [63:0] e, input [63:0] g, input integer tol);
        begin
            cmp_count++;
            if ((^g) === 1'bx || $signed(g - e) > tol || $signed(e - g) > tol)
            begin
                errors++;
                $display("[ERR] %s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    // latch and read back the 64-bit count
    task automatic snap(input integer tm);
        begin
            apb(rg(tm, `GTG_OFF_SNAP_TRG), 1, $random(seed));
            apb(rg(tm, `GTG_OFF_SNAP_LO), 0, 0);
            sv[31:0] = rd;
            apb(rg(tm, `GTG_OFF_SNAP_HI), 0, 0);
            sv[63:32] = rd;
        end
    endtask
    task automatic run(input integer tm, input [31:0] c, input integer cyc);
        begin
            v = sv;
            apb(rg(tm, `GTG_OFF_CFG), 1, c);
            repeat (cyc) @(posedge sys_clk);
            apb(rg(tm, `GTG_OFF_CFG), 1, c & 32'h7fffffff);
            snap(tm);
        end
    endtask
    task automatic summarize;
        begin
            $display("comparisons %0d mismatches %0d", cmp_count, errors);
            if (errors == 0 && cmp_count > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask

    initial
    begin
        #1000000;
        errors++;
        summarize;
    end

    initial
    begin
        {psel, penable, pwrite, watchdogTimeout, resetn} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        {errors, cmp_count, edgeSeen[0], edgeSeen[1]} = 128'h0;
        seed = 32'hf904;
        repeat (5) @(posedge sys_clk);
        resetn <= 1'b1;
        apb(`GTG_T1_BASE, 0, 0);
        chk("config reset", 32'h40002000, rd);
        apb(`GTG_INT_RAW, 1, 7);
        apb(`GTG_INT_RAW, 0, 0);
        chk("raw read only", 0, rd);
        apb(8'hf0, 0, 0);
        chk("unmapped error", 1, err);
        $display("test reset and map done");
        for (t = 0; t < 2; t++)
        begin
            v = {$random(seed), $random(seed)};
            apb(rg(t, `GTG_OFF_LD_LO), 1, v[31:0]);
            apb(rg(t, `GTG_OFF_LD_HI), 1, v[63:32]);
            snap(t);
            chk("count untouched", 0, sv);
            apb(rg(t, `GTG_OFF_LD_TRG), 1, $random(seed));
            snap(t);
            chk("reloaded", v, sv);
            d = 1 + $unsigned($random(seed)) % 4;
            run(t, cfgw(1, 1, 0, d[15:0], 0, 0, 0, 0), 200);
            near("count up", v + 203 / d, sv, 2);
            v = sv;
            repeat (50) @(posedge sys_clk);
            snap(t);
            chk("count held", v, sv);
            apb(rg(t, `GTG_OFF_CFG), 1, cfgw(1, 1, 0, d[15:0], 0, 0, 0, 0));
            repeat (100) @(posedge sys_clk);
            run(t, cfgw(1, 0, 0, d[15:0], 0, 0, 0, 0), 100);
            near("direction flip", v, sv, 2);
            run(t, cfgw(1, 1, 0, 16'h0000, 0, 0, 0, 0), 300);
            chk("divisor zero", v, sv);
            run(t, cfgw(1, 1, 0, 16'h0001, 0, 0, 0, 1), 400);
            near("crystal source", v + 4030 / 74, sv, 3);
        end
        $display("test counting done");
        for (k = 0; k < 4; k++)
        begin
            t = k % 2;
            u = k / 2;
            apb(rg(t, `GTG_OFF_LD_LO), 1, 0);
            apb(rg(t, `GTG_OFF_LD_HI), 1, 0);
            apb(rg(t, `GTG_OFF_LD_TRG), 1, 0);
            alm = 30 + $unsigned($random(seed)) % 20;
            apb(rg(t, `GTG_OFF_ALM_LO), 1, alm);
            apb(rg(t, `GTG_OFF_ALM_HI), 1, 0);
            x0 = edgeSeen[t];
            apb(rg(t, `GTG_OFF_CFG), 1, cfgw(1, 1, u, 1, 1, 1, 1, 0));
            for (d = 0; d < 300 && timerLevelIrq[t] !== 1'b1; d++)
                @(posedge sys_clk);
            chk("level raised", 1, timerLevelIrq[t]);
            apb(rg(t, `GTG_OFF_CFG), 0, 0);
            chk("alarm disarmed", 0, rd[`GTG_CFG_ALM_EN]);
            snap(t);
            chk("reload at alarm", u, sv < alm);
            repeat (60) @(posedge sys_clk);
            chk("one edge pulse", x0 + 1, edgeSeen[t]);
            apb(`GTG_INT_RAW, 0, 0);
            chk("raw set", 1 << t, rd);
            apb(`GTG_INT_ENA, 1, 0);
            apb(`GTG_INT_ST, 0, 0);
            chk("status masked", 0, rd);
            apb(`GTG_INT_ENA, 1, 1 << t);
            apb(`GTG_INT_ST, 0, 0);
            chk("status passed", 1 << t, rd);
            apb(`GTG_INT_CLR, 1, 1 << t);
            apb(`GTG_INT_RAW, 0, 0);
            chk("raw cleared", 0, rd);
            chk("level cleared", 0, timerLevelIrq[t]);
            apb(rg(t, `GTG_OFF_CFG), 1, cfgw(0, 1, 0, 1, 0, 0, 0, 0));
        end
        $display("test alarm done");
        for (k = 0; k < 4; k++)
        begin
            t = k % 2;
            u = k / 2;
            apb(rg(t, `GTG_OFF_LD_LO), 1, u ? 1000 : 10);
            apb(rg(t, `GTG_OFF_LD_TRG), 1, 0);
            apb(rg(t, `GTG_OFF_ALM_LO), 1, 500);
            x0 = edgeSeen[t];
            apb(rg(t, `GTG_OFF_CFG), 1, cfgw(0, u, 0, 1, !u, u, 0, 0));
            repeat (20) @(posedge sys_clk);
            apb(`GTG_INT_RAW, 0, 0);
            chk("unarmed quiet", 0, rd);
            apb(rg(t, `GTG_OFF_CFG), 1, cfgw(0, u, 0, 1, !u, u, 1, 0));
            repeat (4) @(posedge sys_clk);
            apb(`GTG_INT_RAW, 0, 0);
            chk("late alarm", 1 << t, rd);
            chk("level gating", u, timerLevelIrq[t]);
            chk("edge gating", x0 + !u, edgeSeen[t]);
            apb(`GTG_INT_CLR, 1, 1 << t);
        end
        $display("test late alarm done");
        watchdogTimeout <= 1'b1;
        @(posedge sys_clk);
        watchdogTimeout <= 1'b0;
        repeat (3) @(posedge sys_clk);
        apb(`GTG_INT_RAW, 0, 0);
        chk("watchdog raw", 4, rd);
        chk("watchdog level", 1, watchdogLevelIrq);
        apb(`GTG_INT_ENA, 1, 4);
        apb(`GTG_INT_ST, 0, 0);
        chk("watchdog masked", 4, rd);
        apb(`GTG_INT_CLR, 0, 0);
        chk("clear reads zero", 0, rd);
        apb(`GTG_INT_CLR, 1, 4);
        apb(`GTG_INT_RAW, 0, 0);
        chk("watchdog cleared", 0, rd);
        $display("test watchdog done");
        summarize;
    end
endmodule // test_gtg_timer_group
